// File: hdl/pfst_pkg.sv
// constants for the status, monitor and trim register slice
// assumes a 250 MHz core clock and a decoded register port in front
package pfst_pkg;
  // register addresses
  localparam logic [15:0] ADDR_LATCHED_FLAGS_TWO = 16'hFE82;
  localparam logic [15:0] ADDR_PWM_VALUE_MSBS    = 16'hFE84;
  localparam logic [15:0] ADDR_LINE_PERIOD_COUNT = 16'hFE85;
  localparam logic [15:0] ADDR_TEMPERATURE       = 16'hFE86;
  localparam logic [15:0] ADDR_OFFSET_TRIM_HL    = 16'hFE8E;
  localparam logic [15:0] ADDR_GAIN_TRIM_HL      = 16'hFE8F;
  localparam logic [15:0] ADDR_LL_GAIN_LOW_LINE  = 16'hFE90;
  localparam logic [15:0] ADDR_LL_ZERO_LOW_LINE  = 16'hFE91;
  localparam logic [15:0] ADDR_LL_GAIN_HIGH_LINE = 16'hFE92;
  localparam logic [15:0] ADDR_LL_ZERO_HIGH_LINE = 16'hFE93;
  localparam logic [15:0] ADDR_AVG_OUTPUT_POWER  = 16'hFE94;
  // latched flag bit positions
  localparam int BIT_LOW_POWER   = 5;
  localparam int BIT_FAST_LOOP   = 4;
  localparam int BIT_CORE_OV     = 3;
  localparam int BIT_IO_OV       = 2;
  localparam int BIT_IO_UV       = 1;
  localparam logic [7:0] FLAG_USED_MASK = 8'h3E;
  // trim field layout
  localparam int TRIM_SIGN_BIT   = 7;
  localparam int TRIM_MAG_W      = 7;
  // one count is 0.0625/128 = 1/2048 of the reference
  localparam int TRIM_SCALE_SHIFT = 11;
  // full scale power 2^16, so one offset count is 2^16/2^11
  localparam int OFFSET_COUNT_SHIFT = 16 - TRIM_SCALE_SHIFT;
  // reset values
  localparam logic [7:0]  RST_BYTE = 8'h00;
  localparam logic [15:0] RST_WORD = 16'h0000;
  // timing
  localparam real CLK_PERIOD_NS  = 4.0;
  localparam real LINE_LSB_US    = 163.84;
  localparam int  LINE_LSB_CYCLES =
    $rtoi(LINE_LSB_US * 1000.0 / CLK_PERIOD_NS + 0.5); // round, not truncate
  // line cycles in the power average
  localparam int AVG_CYCLES_LOG2 = 4;
endpackage : pfst_pkg

// File: hdl/pfst_line_period.sv
// line period meter: synchronises the line sense pin and counts its period
// assumes the sense input is a squared line signal from a comparator pin
`timescale 1ns/1ps
`default_nettype none
module pfst_line_period #(
  parameter int LSB_CYCLES = pfst_pkg::LINE_LSB_CYCLES
) (
  input  wire logic       sys_clk,
  input  wire logic       nrst,
  input  wire logic       line_voltage_sense,
  output logic [7:0]      period_r,
  output logic            period_upd_r
);
  logic [2:0]  sync_r;
  logic        level_r;
  logic [31:0] pre_r;
  logic [7:0]  cnt_r;
  logic        rise;

  // three stage synchroniser, each stage feeds the next
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      sync_r <= 3'h0;
    end else begin
      sync_r <= {sync_r[1:0], line_voltage_sense};
    end
  end

  // a rising change counts once sync_r[1] and sync_r[2] agree
  assign rise = sync_r[1] & sync_r[2] & ~level_r;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      level_r <= 1'b0;
    end else if (sync_r[1] == sync_r[2]) begin
      level_r <= sync_r[2];
    end
  end

  // prescaler and saturating period count between rising edges
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      pre_r        <= 32'h0;
      cnt_r        <= 8'h00;
      period_r     <= 8'h00;
      period_upd_r <= 1'b0;
    end else begin
      period_upd_r <= rise;
      if (rise) begin
        period_r <= cnt_r;
        cnt_r    <= 8'h00;
        pre_r    <= 32'h0;
      end else if (pre_r == 32'(LSB_CYCLES - 1)) begin
        pre_r <= 32'h0;
        if (cnt_r != 8'hFF) begin
          cnt_r <= cnt_r + 8'h01;
        end
      end else begin
        pre_r <= pre_r + 32'h1;
      end
    end
  end
endmodule : pfst_line_period
`default_nettype wire

// File: hdl/pfst_regs.sv
// status, monitor and trim register slice of the power factor controller
// assumes the serial command layer presents a decoded register port
// and that condition inputs are produced on sys_clk
`timescale 1ns/1ps
`default_nettype none
module pfst_regs #(
  parameter int LINE_LSB_CYCLES = pfst_pkg::LINE_LSB_CYCLES
) (
  input  wire logic        sys_clk,
  input  wire logic        nrst,
  input  wire logic [15:0] reg_addr,
  input  wire logic        reg_wr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_rd,
  output logic [15:0]      reg_rdata_r,
  input  wire logic        low_power_cond,
  input  wire logic        fast_loop_active,
  input  wire logic        core_rail_over_voltage,
  input  wire logic        io_rail_over_voltage,
  input  wire logic        io_rail_under_voltage,
  input  wire logic [9:0]  pwm_value,
  input  wire logic        line_voltage_sense,
  input  wire logic [11:0] temperature_sense,
  input  wire logic        high_line,
  input  wire logic        light_load,
  input  wire logic        light_load_tune_en,
  input  wire logic [15:0] raw_power,
  input  wire logic [15:0] cycle_power,
  input  wire logic        cycle_power_vld,
  output logic [15:0]      trimmed_power_r,
  output logic [15:0]      averaged_power_r,
  output logic             ll_override_r,
  output logic [7:0]       cl_gain_r,
  output logic [7:0]       cl_zero_r
);
  logic [7:0]  flags_r;
  logic [7:0]  flag_set;
  logic        flag_clr;
  logic [7:0]  offset_trim_r;
  logic [7:0]  gain_trim_r;
  logic [7:0]  ll_gain_low_r;
  logic [7:0]  ll_zero_low_r;
  logic [7:0]  ll_gain_high_r;
  logic [7:0]  ll_zero_high_r;
  logic [7:0]  line_period;
  logic        line_period_upd;
  logic [19:0] avg_acc_r;
  logic [3:0]  avg_cnt_r;
  logic [19:0] avg_sum;
  logic [22:0] gain_prod;
  logic [17:0] trim_sum;
  logic [17:0] gain_adj;
  logic [17:0] off_adj;

  // line period meter with pin synchroniser
  pfst_line_period #(
    .LSB_CYCLES (LINE_LSB_CYCLES)
  ) u_period (
    .sys_clk            (sys_clk),
    .nrst               (nrst),
    .line_voltage_sense (line_voltage_sense),
    .period_r           (line_period),
    .period_upd_r       (line_period_upd)
  );

  // condition vector into flag positions, reserved bits stay zero
  always_comb begin
    flag_set = 8'h00;
    flag_set[pfst_pkg::BIT_LOW_POWER] = low_power_cond;
    flag_set[pfst_pkg::BIT_FAST_LOOP] = fast_loop_active;
    flag_set[pfst_pkg::BIT_CORE_OV]   = core_rail_over_voltage;
    flag_set[pfst_pkg::BIT_IO_OV]     = io_rail_over_voltage;
    flag_set[pfst_pkg::BIT_IO_UV]     = io_rail_under_voltage;
  end

  assign flag_clr = reg_rd && (reg_addr == pfst_pkg::ADDR_LATCHED_FLAGS_TWO);

  // sticky flags; a new event in the clearing read cycle survives
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      flags_r <= pfst_pkg::RST_BYTE;
    end else if (flag_clr) begin
      flags_r <= flag_set & pfst_pkg::FLAG_USED_MASK;
    end else begin
      flags_r <= (flags_r | flag_set) & pfst_pkg::FLAG_USED_MASK;
    end
  end

  // writable trim and tuning registers; other addresses ignore writes
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      offset_trim_r  <= pfst_pkg::RST_BYTE;
      gain_trim_r    <= pfst_pkg::RST_BYTE;
      ll_gain_low_r  <= pfst_pkg::RST_BYTE;
      ll_zero_low_r  <= pfst_pkg::RST_BYTE;
      ll_gain_high_r <= pfst_pkg::RST_BYTE;
      ll_zero_high_r <= pfst_pkg::RST_BYTE;
    end else if (reg_wr) begin
      case (reg_addr)
        pfst_pkg::ADDR_OFFSET_TRIM_HL:    offset_trim_r  <= reg_wdata;
        pfst_pkg::ADDR_GAIN_TRIM_HL:      gain_trim_r    <= reg_wdata;
        pfst_pkg::ADDR_LL_GAIN_LOW_LINE:  ll_gain_low_r  <= reg_wdata;
        pfst_pkg::ADDR_LL_ZERO_LOW_LINE:  ll_zero_low_r  <= reg_wdata;
        pfst_pkg::ADDR_LL_GAIN_HIGH_LINE: ll_gain_high_r <= reg_wdata;
        pfst_pkg::ADDR_LL_ZERO_HIGH_LINE: ll_zero_high_r <= reg_wdata;
        default: ;
      endcase
    end
  end

  // read data, registered one cycle after the read strobe
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata_r <= pfst_pkg::RST_WORD;
    end else if (reg_rd) begin
      case (reg_addr)
        pfst_pkg::ADDR_LATCHED_FLAGS_TWO: reg_rdata_r <= {8'h00, flags_r};
        pfst_pkg::ADDR_PWM_VALUE_MSBS:
          reg_rdata_r <= {8'h00, pwm_value[9:2]};
        pfst_pkg::ADDR_LINE_PERIOD_COUNT:
          reg_rdata_r <= {8'h00, line_period};
        pfst_pkg::ADDR_TEMPERATURE:
          reg_rdata_r <= {4'h0, temperature_sense};
        pfst_pkg::ADDR_OFFSET_TRIM_HL:
          reg_rdata_r <= {8'h00, offset_trim_r};
        pfst_pkg::ADDR_GAIN_TRIM_HL:
          reg_rdata_r <= {8'h00, gain_trim_r};
        pfst_pkg::ADDR_LL_GAIN_LOW_LINE:
          reg_rdata_r <= {8'h00, ll_gain_low_r};
        pfst_pkg::ADDR_LL_ZERO_LOW_LINE:
          reg_rdata_r <= {8'h00, ll_zero_low_r};
        pfst_pkg::ADDR_LL_GAIN_HIGH_LINE:
          reg_rdata_r <= {8'h00, ll_gain_high_r};
        pfst_pkg::ADDR_LL_ZERO_HIGH_LINE:
          reg_rdata_r <= {8'h00, ll_zero_high_r};
        pfst_pkg::ADDR_AVG_OUTPUT_POWER:
          reg_rdata_r <= averaged_power_r;
        default: reg_rdata_r <= pfst_pkg::RST_WORD;
      endcase
    end
  end

  // high line power meter trim: magnitudes scaled by 1/2048
  assign gain_prod = raw_power * gain_trim_r[pfst_pkg::TRIM_MAG_W-1:0];
  assign gain_adj  = {6'h00,
                      gain_prod[22:pfst_pkg::TRIM_SCALE_SHIFT]};
  assign off_adj   = {6'h00, offset_trim_r[pfst_pkg::TRIM_MAG_W-1:0],
                      5'h00};

  always_comb begin
    trim_sum = {2'h0, raw_power};
    if (gain_trim_r[pfst_pkg::TRIM_SIGN_BIT]) begin
      trim_sum = trim_sum - gain_adj;
    end else begin
      trim_sum = trim_sum + gain_adj;
    end
    if (offset_trim_r[pfst_pkg::TRIM_SIGN_BIT]) begin
      trim_sum = trim_sum - off_adj;
    end else begin
      trim_sum = trim_sum + off_adj;
    end
  end

  // corrected reading, clamped to the 16-bit range, trim only at high line
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      trimmed_power_r <= pfst_pkg::RST_WORD;
    end else if (!high_line) begin
      trimmed_power_r <= raw_power;
    end else if (trim_sum[17]) begin
      trimmed_power_r <= 16'h0000; // went negative
    end else if (trim_sum[16]) begin
      trimmed_power_r <= 16'hFFFF;
    end else begin
      trimmed_power_r <= trim_sum[15:0];
    end
  end

  // light load filter selection by input line
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      ll_override_r <= 1'b0;
      cl_gain_r     <= pfst_pkg::RST_BYTE;
      cl_zero_r     <= pfst_pkg::RST_BYTE;
    end else begin
      ll_override_r <= light_load && light_load_tune_en;
      cl_gain_r <= high_line ? ll_gain_high_r : ll_gain_low_r;
      cl_zero_r <= high_line ? ll_zero_high_r : ll_zero_low_r;
    end
  end

  // average of sixteen per-cycle power values
  assign avg_sum = avg_acc_r + {4'h0, cycle_power};

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      avg_acc_r        <= 20'h00000;
      avg_cnt_r        <= 4'h0;
      averaged_power_r <= pfst_pkg::RST_WORD;
    end else if (cycle_power_vld) begin
      avg_cnt_r <= avg_cnt_r + 4'h1;
      if (avg_cnt_r == 4'hF) begin
        averaged_power_r <= avg_sum[19:pfst_pkg::AVG_CYCLES_LOG2];
        avg_acc_r        <= 20'h00000;
      end else begin
        avg_acc_r <= avg_sum;
      end
    end
  end

  // checks
  property p_low_power_set;
    @(posedge sys_clk) disable iff (!nrst)
    low_power_cond |=> flags_r[pfst_pkg::BIT_LOW_POWER];
  endproperty
  a_low_power_set: assert property (p_low_power_set)
    else $error("low power flag not set");

  property p_fast_loop_set;
    @(posedge sys_clk) disable iff (!nrst)
    fast_loop_active |=> flags_r[pfst_pkg::BIT_FAST_LOOP];
  endproperty
  a_fast_loop_set: assert property (p_fast_loop_set)
    else $error("fast loop flag not set");

  property p_core_ov_set;
    @(posedge sys_clk) disable iff (!nrst)
    core_rail_over_voltage |=> flags_r[pfst_pkg::BIT_CORE_OV];
  endproperty
  a_core_ov_set: assert property (p_core_ov_set)
    else $error("core overvoltage flag not set");

  property p_io_rail_set;
    @(posedge sys_clk) disable iff (!nrst)
    io_rail_over_voltage |=> flags_r[pfst_pkg::BIT_IO_OV];
  endproperty
  a_io_rail_set: assert property (p_io_rail_set)
    else $error("io overvoltage flag not set");

  property p_io_uv_set;
    @(posedge sys_clk) disable iff (!nrst)
    io_rail_under_voltage |=> flags_r[pfst_pkg::BIT_IO_UV];
  endproperty
  a_io_uv_set: assert property (p_io_uv_set)
    else $error("io undervoltage flag not set");

  property p_pwm_read;
    @(posedge sys_clk) disable iff (!nrst)
    reg_rd && reg_addr == pfst_pkg::ADDR_PWM_VALUE_MSBS |=>
      reg_rdata_r == {8'h00, $past(pwm_value[9:2])};
  endproperty
  a_pwm_read: assert property (p_pwm_read)
    else $error("pwm read value wrong");

  property p_flags_hold;
    @(posedge sys_clk) disable iff (!nrst)
    flags_r[pfst_pkg::BIT_CORE_OV] && !flag_clr ##1 !flag_clr
      |=> flags_r[pfst_pkg::BIT_CORE_OV];
  endproperty
  a_flags_hold: assert property (p_flags_hold)
    else $error("latched flag dropped without read");

  property p_read_clears;
    @(posedge sys_clk) disable iff (!nrst)
    flag_clr && flag_set == 8'h00 |=> flags_r == 8'h00;
  endproperty
  a_read_clears: assert property (p_read_clears)
    else $error("read did not clear flags");

  property p_clear_keeps_set;
    @(posedge sys_clk) disable iff (!nrst)
    flag_clr |=> flags_r == ($past(flag_set) & pfst_pkg::FLAG_USED_MASK);
  endproperty
  a_clear_keeps_set: assert property (p_clear_keeps_set)
    else $error("clearing read lost a new flag event");

  property p_reserved_zero;
    @(posedge sys_clk) disable iff (!nrst)
    (flags_r & ~pfst_pkg::FLAG_USED_MASK) == 8'h00;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("reserved flag bit set");

  property p_ll_low_line;
    @(posedge sys_clk) disable iff (!nrst)
    !high_line ##1 !high_line |=> cl_gain_r == $past(ll_gain_low_r) &&
      cl_zero_r == $past(ll_zero_low_r);
  endproperty
  a_ll_low_line: assert property (p_ll_low_line)
    else $error("low line filter values not selected");

  property p_ll_high_line;
    @(posedge sys_clk) disable iff (!nrst)
    high_line |=> cl_gain_r == $past(ll_gain_high_r) &&
      cl_zero_r == $past(ll_zero_high_r);
  endproperty
  a_ll_high_line: assert property (p_ll_high_line)
    else $error("high line filter values not selected");

  property p_ll_override;
    @(posedge sys_clk) disable iff (!nrst)
    1'b1 |=> ll_override_r ==
      ($past(light_load) && $past(light_load_tune_en));
  endproperty
  a_ll_override: assert property (p_ll_override)
    else $error("light load override wrong");

  property p_trim_low_line;
    @(posedge sys_clk) disable iff (!nrst)
    !high_line |=> trimmed_power_r == $past(raw_power);
  endproperty
  a_trim_low_line: assert property (p_trim_low_line)
    else $error("trim applied outside high line");

  c_flag_read_clear: cover property (
    @(posedge sys_clk) disable iff (!nrst)
    flags_r != 8'h00 ##1 flag_clr ##1 flags_r == 8'h00);
  c_ll_high_line: cover property (
    @(posedge sys_clk) disable iff (!nrst) ll_override_r && high_line);
  c_set_during_clear: cover property (
    @(posedge sys_clk) disable iff (!nrst) flag_clr && flag_set != 8'h00);
  c_period_update: cover property (
    @(posedge sys_clk) disable iff (!nrst) line_period_upd);
  c_average_done: cover property (
    @(posedge sys_clk) disable iff (!nrst)
    cycle_power_vld && avg_cnt_r == 4'hF);
endmodule : pfst_regs
`default_nettype wire

// File: verification/pfst_host_model.sv
// host side model: issues register reads and writes on the decoded port
// assumes strobes are launched 1 ns after sys_clk rises, one per access
`timescale 1ns/1ps
`default_nettype none
module pfst_host_model (
  input  wire logic   sys_clk,
  output logic [15:0] reg_addr,
  output logic        reg_wr,
  output logic [7:0]  reg_wdata,
  output logic        reg_rd
);
  // idle values at time zero
  initial begin
    reg_addr  = 16'h0000;
    reg_wr    = 1'b0;
    reg_wdata = 8'h00;
    reg_rd    = 1'b0;
  end
  // one strobe cycle, then address and data are scrambled, not held
  task automatic access(input logic [15:0] addr, input logic wr,
                        input logic [7:0] data);
    @(posedge sys_clk);
    #1;
    reg_addr  = addr;
    reg_wdata = data;
    reg_wr    = wr;
    reg_rd    = ~wr;
    @(posedge sys_clk);
    #1;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_addr  = ~addr;
    reg_wdata = ~data;
  endtask : access
endmodule : pfst_host_model
`default_nettype wire

// File: verification/pfc_status_trim_registers_bench.sv
// self-checking bench for the status, monitor and trim register slice
// assumes pfst_regs and the host model; reads checked from a queue
`timescale 1ns/1ps
`default_nettype none
module pfc_status_trim_registers_bench;
  logic        sys_clk, nrst, line_sense, high_line, light_load, tune_en;
  logic [4:0]  conds;
  logic [9:0]  pwm;
  logic [11:0] temp;
  logic [15:0] raw, cyc_pwr, reg_addr, rdata, trimmed, avg;
  logic        cyc_vld, reg_wr, reg_rd, pend, ovr;
  logic [7:0]  reg_wdata, gain, zero, og, gg;
  logic [7:0]  lv [4];
  logic [16:0] exp_q [$];
  logic [16:0] e;
  int          bad_count, total_checks, sum;

  // clock generator
  always #2 sys_clk = ~sys_clk;

  pfst_host_model HOST (.sys_clk(sys_clk), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd));

  pfst_regs #(.LINE_LSB_CYCLES(8)) DUT (.sys_clk(sys_clk), .nrst(nrst),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .reg_rd(reg_rd), .reg_rdata_r(rdata), .low_power_cond(conds[4]),
    .fast_loop_active(conds[3]), .core_rail_over_voltage(conds[2]),
    .io_rail_over_voltage(conds[1]), .io_rail_under_voltage(conds[0]),
    .pwm_value(pwm), .line_voltage_sense(line_sense),
    .temperature_sense(temp), .high_line(high_line),
    .light_load(light_load), .light_load_tune_en(tune_en),
    .raw_power(raw), .cycle_power(cyc_pwr), .cycle_power_vld(cyc_vld),
    .trimmed_power_r(trimmed), .averaged_power_r(avg),
    .ll_override_r(ovr), .cl_gain_r(gain), .cl_zero_r(zero));

  task automatic chk(input string name, input logic [15:0] ex, got);
    total_checks++;
    if (ex !== got) begin
      $display("unexpected %s expected %h seen %h", name, ex, got);
      bad_count++;
    end
  endtask : chk

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : print_verdict

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : cyc

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    HOST.access(a, 1'b1, d);
  endtask : wr

  // note the expected read data, bit 16 allows one count either way
  task automatic rd(input logic [15:0] a, input logic [16:0] x);
    exp_q.push_back(x);
    HOST.access(a, 1'b0, 8'h00);
  endtask : rd

  task automatic line_per(input int p);
    line_sense = 1'b1;
    cyc(p / 2);
    line_sense = 1'b0;
    cyc(p - p / 2);
  endtask : line_per

  function automatic logic [15:0] exp_trim(logic [15:0] r,
                                           logic [7:0] o, g, logic hl);
    int v, gd, od;
    gd = (int'(r) * int'(g[6:0])) >>> 11;
    od = int'(o[6:0]) << 5;
    v  = int'(r);
    if (hl) v = v + (g[7] ? -gd : gd) + (o[7] ? -od : od);
    if (v < 0) v = 0;
    if (v > 65535) v = 65535;
    return v[15:0];
  endfunction : exp_trim

  // read watcher: data is due the cycle after the strobe
  always @(negedge sys_clk) begin
    if (pend) begin
      if (exp_q.size() == 0) chk("read queue", 16'h0001, 16'h0000);
      else begin
        e = exp_q.pop_front();
        if (e[16] && rdata >= e[15:0] - 1 && rdata <= e[15:0] + 1)
          chk("line period", e[15:0], e[15:0]);
        else chk("read data", e[15:0], rdata);
      end
    end
    pend = reg_rd;
  end

  // hang guard
  initial begin
    #300000;
    bad_count++;
    print_verdict();
  end

  // main sequence
  initial begin
    {sys_clk, nrst, line_sense, high_line, light_load, tune_en} = '0;
    {conds, pwm, temp, raw, cyc_pwr, cyc_vld, pend} = '0;
    void'($urandom(88));
    repeat (16) @(posedge sys_clk);
    #1;
    nrst = 1'b1;
    for (int a = 16'hFE82; a <= 16'hFE94; a++)
      rd(16'(a), 17'h00000);
    $display("test reset and unmapped done");
    for (int i = 0; i < 5; i++) begin
      conds = 5'h01 << i;
      cyc(1);
      conds = 5'h00;
      cyc(2);
      rd(16'hFE82, 17'(8'h02 << i));
      rd(16'hFE82, 17'h00000);
    end
    conds = 5'h1F;
    cyc(1);
    conds = 5'h00;
    wr(16'hFE82, 8'hFF);
    rd(16'hFE82, 17'h0003E);
    // event held through the clearing read survives it
    conds = 5'h04;
    rd(16'hFE82, 17'h00008);
    conds = 5'h00;
    rd(16'hFE82, 17'h00008);
    rd(16'hFE82, 17'h00000);
    $display("test latched flags done");
    repeat (4) begin
      pwm  = 10'($urandom);
      temp = 12'($urandom);
      cyc(1);
      rd(16'hFE84, {9'h000, pwm[9:2]});
      rd(16'hFE86, {5'h00, temp});
    end
    $display("test monitors done");
    repeat (8) begin
      og = 8'($urandom);
      gg = 8'($urandom);
      raw = 16'($urandom);
      high_line = 1'($urandom);
      wr(16'hFE8E, og);
      wr(16'hFE8F, gg);
      rd(16'hFE8E, {9'h000, og});
      rd(16'hFE8F, {9'h000, gg});
      cyc(3);
      chk("trimmed power", exp_trim(raw, og, gg, high_line),
          trimmed);
    end
    $display("test power trim done");
    repeat (6) begin
      for (int k = 0; k < 4; k++) begin
        lv[k] = 8'($urandom);
        wr(16'(16'hFE90 + k), lv[k]);
      end
      {high_line, light_load, tune_en} = 3'($urandom);
      for (int k = 0; k < 4; k++)
        rd(16'(16'hFE90 + k), {9'h000, lv[k]});
      cyc(2);
      chk("loop gain", {8'h00, high_line ? lv[2] : lv[0]},
          {8'h00, gain});
      chk("loop zero", {8'h00, high_line ? lv[3] : lv[1]},
          {8'h00, zero});
      chk("override", {15'h0000, light_load & tune_en},
          {15'h0000, ovr});
    end
    $display("test light load tuning done");
    line_per(160);
    line_per(160);
    rd(16'hFE85, 17'h10014);
    line_per(2400);
    line_per(2400);
    rd(16'hFE85, 17'h000FF);
    $display("test line period done");
    repeat (2) begin
      sum = 0;
      repeat (16) begin
        cyc_pwr = 16'($urandom);
        sum = sum + int'(cyc_pwr);
        cyc_vld = 1'b1;
        cyc(1);
        cyc_vld = 1'b0;
        cyc(1);
      end
      cyc(1);
      chk("average", 16'(sum >> 4), avg);
      rd(16'hFE94, {1'b0, 16'(sum >> 4)});
    end
    $display("test power average done");
    cyc(3);
    print_verdict();
  end
endmodule : pfc_status_trim_registers_bench
`default_nettype wire
